// ==== common/mmd_defs.svh ====
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// ============================================================
// Address map of the 1-Mbyte CPU space.
`define MMD_ADDR_LAST      20'hFFFFF
`define MMD_SFR_LO         20'h00000
`define MMD_SFR_HI         20'h002FF
`define MMD_RAM_LO         20'h00400
`define MMD_RAM_SIZE       20'h00400
`define MMD_DFL_LO         20'h02400
`define MMD_DFL_HI         20'h02BFF
`define MMD_ROM_TOP        20'h0FFFF
`define MMD_ROM_SIZE       20'h04000
`define MMD_VEC_LO         20'h0FFDC
`define MMD_HAS_DFLASH     1'b1

// ============================================================
// Register indices; the APB byte address is four times the index.
`define MMD_IDX_VDC1       10'h031
`define MMD_IDX_VDC2       10'h032
`define MMD_IDX_VM1        10'h036
`define MMD_IDX_VM2        10'h037
`define MMD_IDX_VM0        10'h038
`define MMD_IDX_TMRC_IRQ   10'h047
`define MMD_IDX_TMRE_IRQ   10'h04A
`define MMD_IDX_KEY_IRQ    10'h04D
`define MMD_IDX_ADC_IRQ    10'h04E
`define MMD_IDX_SHARED_IRQ 10'h04F
`define MMD_IDX_UATX_IRQ   10'h051
`define MMD_IDX_UARX_IRQ   10'h052
`define MMD_IDX_UBTX_IRQ   10'h053
`define MMD_IDX_UBRX_IRQ   10'h054
`define MMD_IDX_TMRA_IRQ   10'h056
`define MMD_IDX_TMRB_IRQ   10'h058
`define MMD_IDX_PIN1_IRQ   10'h059
`define MMD_IDX_PIN3_IRQ   10'h05A
`define MMD_IDX_PIN0_IRQ   10'h05D
`define MMD_IDX_PMODE      10'h07C
`define MMD_IDX_CLKSEL     10'h07D
`define MMD_IDX_REGION     10'h07E

// ============================================================
// Reset values and masks.
`define MMD_VDC1_RST       8'h08
`define MMD_VDC2_RST_LOW   8'h00
`define MMD_VDC2_RST_HIGH  8'h20
`define MMD_VM1_RST        8'h08
`define MMD_VM2_RST        8'h00
`define MMD_VM0_RST_LOW    8'h00
`define MMD_VM0_RST_HIGH   8'h41
`define MMD_VM_KEEP_MASK   8'h0C
`define MMD_IRQ_CLR_MASK   8'h07
`define MMD_EXT_CLR_MASK   8'h37
`define MMD_PMODE_RST      8'h00
`define MMD_CLKSEL_RST     8'h00

// ============================================================
// Field positions.
`define MMD_TWOWIRE_SEL_BIT 7
`define MMD_CLK_SRC_BIT     0
`define MMD_OSC_SPEED_BIT   1

`endif

// ==== common/mmd_pkg.sv ====
package mmd_pkg;

  // Memory region picked by one CPU address.
  typedef enum logic [2:0] {
    REGION_NONE,
    REGION_SFR,
    REGION_RAM,
    REGION_DFLASH,
    REGION_ROM
  } mmd_region_t;

  // Source feeding the system clock.
  typedef enum logic [1:0] {
    CLK_EXTERNAL,
    CLK_ONCHIP_LOW,
    CLK_ONCHIP_HIGH
  } mmd_clk_src_t;

endpackage

// ==== hdl/mmd_region_decode.sv ====
`timescale 1ns/1ps
`include "mmd_defs.svh"

// Purely combinational map of a 20-bit address onto one region.
module mmd_region_decode (
  input  wire logic [19:0]         addr,
  output mmd_pkg::mmd_region_t     region,
  output logic                     in_vector
);

  // ============================================================
  // Region bounds.
  localparam logic [19:0] RAM_HI = `MMD_RAM_LO + `MMD_RAM_SIZE - 20'h00001;
  localparam logic [19:0] ROM_LO = `MMD_ROM_TOP - `MMD_ROM_SIZE + 20'h00001;

  wire hit_sfr = (addr <= `MMD_SFR_HI);
  wire hit_ram = (addr >= `MMD_RAM_LO) && (addr <= RAM_HI);
  wire hit_dfl = `MMD_HAS_DFLASH && (addr >= `MMD_DFL_LO) && (addr <= `MMD_DFL_HI);
  wire hit_rom = (addr >= ROM_LO) && (addr <= `MMD_ROM_TOP);

  // The areas never overlap, so a priority chain still gives one hit only.
  assign region = hit_sfr ? mmd_pkg::REGION_SFR :
                  hit_ram ? mmd_pkg::REGION_RAM :
                  hit_dfl ? mmd_pkg::REGION_DFLASH :
                  hit_rom ? mmd_pkg::REGION_ROM : mmd_pkg::REGION_NONE;

  // The vector table is the top slice of program ROM.
  assign in_vector = hit_rom && (addr >= `MMD_VEC_LO);

endmodule

// ==== hdl/mmd_top.sv ====
// Operation
// - Decode a full 20-bit, one-megabyte byte space.
// - Program ROM ends at 0FFFFh, grows downward.
// - Vector table occupies the top of ROM.
// - RAM starts at 00400h and grows upward.
// - Register area spans 00000h to 002FFh.
// - Unused register locations are reserved, not stored.
// - Data flash at 02400h to 02BFFh when fitted.
// - Detect register one resets on hardware or power-on.
// - Monitor one/two bits 2,3 survive soft resets.
// - Monitor zero reset value depends on option bit.
// - Detect register two reset value depends on option.
// - Interrupt controls clear low bits; pins also 5:4.
// - One interrupt control shared, chosen by pin mode.
// - Clock from external, slow or fast on-chip oscillator.
`timescale 1ns/1ps
`include "mmd_defs.svh"

module mmd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [19:0] cpu_addr,
  input  wire logic        cpu_valid,
  input  wire logic        rst_hw,
  input  wire logic        rst_por,
  input  wire logic        rst_sw,
  input  wire logic        rst_wdt,
  input  wire logic        rst_mon0,
  input  wire logic        rst_mon1,
  input  wire logic        rst_mon2,
  input  wire logic        monitor_zero_reset_option,
  output logic             sel_sfr,
  output logic             sel_ram,
  output logic             sel_dflash,
  output logic             sel_rom,
  output logic             sel_vector,
  output logic             sel_none,
  output logic      [7:0]  voltage_detect_ctrl_1,
  output logic      [7:0]  voltage_detect_ctrl_2,
  output logic      [7:0]  voltage_monitor_one_ctrl,
  output logic      [7:0]  voltage_monitor_two_ctrl,
  output logic      [7:0]  voltage_monitor_zero_ctrl,
  output logic      [111:0] irq_ctrl_flat,
  output logic      [7:0]  serial_irq_ctrl,
  output logic      [7:0]  twowire_irq_ctrl,
  output mmd_pkg::mmd_clk_src_t sys_clk_source
);

  // ============================================================
  // Interrupt control register table.
  localparam int NIRQ = 14;

  // Index of each interrupt control register, in output slot order.
  localparam logic [9:0] IRQ_IDX [0:NIRQ-1] = '{
    `MMD_IDX_TMRC_IRQ, `MMD_IDX_TMRE_IRQ, `MMD_IDX_KEY_IRQ,  `MMD_IDX_ADC_IRQ,
    `MMD_IDX_SHARED_IRQ, `MMD_IDX_UATX_IRQ, `MMD_IDX_UARX_IRQ, `MMD_IDX_UBTX_IRQ,
    `MMD_IDX_UBRX_IRQ, `MMD_IDX_TMRA_IRQ, `MMD_IDX_TMRB_IRQ, `MMD_IDX_PIN1_IRQ,
    `MMD_IDX_PIN3_IRQ, `MMD_IDX_PIN0_IRQ
  };

  // Slot of the shared serial/two-wire interrupt control.
  localparam int SHARED_SLOT = 4;

  // ============================================================
  // Decode functions.

  // True for an external pin interrupt control register.
  function automatic logic is_ext_pin(input logic [9:0] idx);
    is_ext_pin = (idx == `MMD_IDX_PIN0_IRQ) || (idx == `MMD_IDX_PIN1_IRQ) ||
                 (idx == `MMD_IDX_PIN3_IRQ);
  endfunction

  // True for an interrupt control register index.
  function automatic logic is_irq_reg(input logic [9:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NIRQ; i++) begin
      hit = hit | (idx == IRQ_IDX[i]);
    end
    is_irq_reg = hit;
  endfunction

  // True for any index that holds storage; the rest of the area is reserved.
  function automatic logic reg_hit(input logic [9:0] idx);
    reg_hit = (idx == `MMD_IDX_VDC1) || (idx == `MMD_IDX_VDC2) ||
              (idx == `MMD_IDX_VM0) || (idx == `MMD_IDX_VM1) ||
              (idx == `MMD_IDX_VM2) || is_irq_reg(idx) ||
              (idx == `MMD_IDX_PMODE) || (idx == `MMD_IDX_CLKSEL) ||
              (idx == `MMD_IDX_REGION);
  endfunction

  // ============================================================
  // APB access decode.
  wire logic [9:0] widx      = paddr[11:2];                    // Word index of the access.
  wire logic       access    = psel && penable;                // Access phase is open.
  wire logic       wr_commit = access && pready && pwrite;     // Write takes effect here.
  wire logic       mapped    = reg_hit(widx);                  // Index holds storage.
  wire logic       wr_ok     = wr_commit && mapped;            // Write to real storage.

  // ============================================================
  // Reset source classification.

  // Resets that return every voltage register to its start value.
  wire logic full_rst = rst_hw || rst_por || rst_mon0;
  // Resets that spare the voltage registers or parts of them.
  wire logic soft_rst = rst_sw || rst_wdt || rst_mon1 || rst_mon2;
  // Any reset at all clears interrupt control low bits.
  wire logic any_rst  = full_rst || soft_rst;
  // Hardware reset alone with the monitor-zero option set picks the low values.
  wire logic opt_low  = rst_hw && !rst_por && !rst_mon0 && monitor_zero_reset_option;

  // Values loaded by a full reset.
  wire logic [7:0] vdc2_full = opt_low ? `MMD_VDC2_RST_LOW : `MMD_VDC2_RST_HIGH;
  wire logic [7:0] vm0_full  = opt_low ? `MMD_VM0_RST_LOW : `MMD_VM0_RST_HIGH;

  // Soft reset values of monitors one and two keep bits 2 and 3.
  wire logic [7:0] vm1_soft = (voltage_monitor_one_ctrl & `MMD_VM_KEEP_MASK) |
                              (`MMD_VM1_RST & ~`MMD_VM_KEEP_MASK);
  wire logic [7:0] vm2_soft = (voltage_monitor_two_ctrl & `MMD_VM_KEEP_MASK) |
                              (`MMD_VM2_RST & ~`MMD_VM_KEEP_MASK);

  // ============================================================
  // Register storage.
  logic [7:0] irq_q [0:NIRQ-1];   // Interrupt control registers.
  logic [7:0] pin_mode_register;  // Pin mode, holds the two-wire select.
  logic [7:0] clk_sel;            // Clock source and speed select bits.
  mmd_pkg::mmd_region_t last_region; // Region of the latest CPU access.

  // Detect register one: only hardware, power-on or monitor-zero reset it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_detect_ctrl_1 <= `MMD_VDC1_RST;
    end else if (full_rst) begin
      voltage_detect_ctrl_1 <= `MMD_VDC1_RST;
    end else if (wr_ok && widx == `MMD_IDX_VDC1) begin
      voltage_detect_ctrl_1 <= pwdata[7:0];
    end
  end

  // Detect register two: the reset value follows the monitor-zero option.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_detect_ctrl_2 <= `MMD_VDC2_RST_HIGH;
    end else if (full_rst) begin
      voltage_detect_ctrl_2 <= vdc2_full;
    end else if (wr_ok && widx == `MMD_IDX_VDC2) begin
      voltage_detect_ctrl_2 <= pwdata[7:0];
    end
  end

  // Monitor zero control: spared by soft resets, option picks the value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_monitor_zero_ctrl <= `MMD_VM0_RST_HIGH;
    end else if (full_rst) begin
      voltage_monitor_zero_ctrl <= vm0_full;
    end else if (wr_ok && widx == `MMD_IDX_VM0) begin
      voltage_monitor_zero_ctrl <= pwdata[7:0];
    end
  end

  // Monitor one control: soft resets keep bits 2 and 3 only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_monitor_one_ctrl <= `MMD_VM1_RST;
    end else if (full_rst) begin
      voltage_monitor_one_ctrl <= `MMD_VM1_RST;
    end else if (soft_rst) begin
      voltage_monitor_one_ctrl <= vm1_soft;
    end else if (wr_ok && widx == `MMD_IDX_VM1) begin
      voltage_monitor_one_ctrl <= pwdata[7:0];
    end
  end

  // Monitor two control: same partial keep as monitor one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      voltage_monitor_two_ctrl <= `MMD_VM2_RST;
    end else if (full_rst) begin
      voltage_monitor_two_ctrl <= `MMD_VM2_RST;
    end else if (soft_rst) begin
      voltage_monitor_two_ctrl <= vm2_soft;
    end else if (wr_ok && widx == `MMD_IDX_VM2) begin
      voltage_monitor_two_ctrl <= pwdata[7:0];
    end
  end

  // One register per interrupt source, the serial and two-wire units sharing one; any reset clears its low bits.
  for (genvar g = 0; g < NIRQ; g++) begin : g_irq
    // Pin sources also clear bits 4 and 5.
    localparam logic [7:0] CLR = is_ext_pin(IRQ_IDX[g]) ? `MMD_EXT_CLR_MASK : `MMD_IRQ_CLR_MASK;

    // Undefined upper bits simply hold their value through a run-time reset.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_q[g] <= 8'h00;
      end else if (any_rst) begin
        irq_q[g] <= irq_q[g] & ~CLR;
      end else if (wr_ok && widx == IRQ_IDX[g]) begin
        irq_q[g] <= pwdata[7:0];
      end
    end

    // Flat copy of the register for the peripherals.
    assign irq_ctrl_flat[g*8 +: 8] = irq_q[g];
  end

  // Pin mode register; run-time resets return it to its start value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_register <= `MMD_PMODE_RST;
    end else if (any_rst) begin
      pin_mode_register <= `MMD_PMODE_RST;
    end else if (wr_ok && widx == `MMD_IDX_PMODE) begin
      pin_mode_register <= pwdata[7:0];
    end
  end

  // Clock select register; a reset falls back to the external source.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel <= `MMD_CLKSEL_RST;
    end else if (any_rst) begin
      clk_sel <= `MMD_CLKSEL_RST;
    end else if (wr_ok && widx == `MMD_IDX_CLKSEL) begin
      clk_sel <= pwdata[7:0];
    end
  end

  // ============================================================
  // Shared interrupt control routing.
  wire logic twowire_unit_select = pin_mode_register[`MMD_TWOWIRE_SEL_BIT];

  // The register serves one unit; the other sees zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_irq_ctrl  <= 8'h00;
      twowire_irq_ctrl <= 8'h00;
    end else begin
      serial_irq_ctrl  <= twowire_unit_select ? 8'h00 : irq_q[SHARED_SLOT];
      twowire_irq_ctrl <= twowire_unit_select ? irq_q[SHARED_SLOT] : 8'h00;
    end
  end

  // ============================================================
  // System clock source selection.
  wire logic system_clock_source_select = clk_sel[`MMD_CLK_SRC_BIT];
  wire logic onchip_osc_speed_select    = clk_sel[`MMD_OSC_SPEED_BIT];

  // External input unless the on-chip oscillator is chosen, then slow or fast.
  wire mmd_pkg::mmd_clk_src_t next_clk_source =
    !system_clock_source_select ? mmd_pkg::CLK_EXTERNAL :
    onchip_osc_speed_select     ? mmd_pkg::CLK_ONCHIP_HIGH : mmd_pkg::CLK_ONCHIP_LOW;

  // Registered source code.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_source <= mmd_pkg::CLK_EXTERNAL;
    end else begin
      sys_clk_source <= next_clk_source;
    end
  end

  // ============================================================
  // CPU address decode.
  mmd_pkg::mmd_region_t dec_region;  // Region of the present CPU address.
  logic                 dec_vector;  // Address lies in the vector table.

  // All 20 address bits are decoded; nothing aliases.
  mmd_region_decode u_decode (
    .addr      (cpu_addr),
    .region    (dec_region),
    .in_vector (dec_vector)
  );

  // Region selects other than sel_vector are one-hot in the cycle after a valid CPU access, else all low; sel_vector rides with sel_rom.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_sfr    <= 1'b0;
      sel_ram    <= 1'b0;
      sel_dflash <= 1'b0;
      sel_rom    <= 1'b0;
      sel_vector <= 1'b0;
      sel_none   <= 1'b0;
    end else begin
      sel_sfr    <= cpu_valid && dec_region == mmd_pkg::REGION_SFR;
      sel_ram    <= cpu_valid && dec_region == mmd_pkg::REGION_RAM;
      sel_dflash <= cpu_valid && dec_region == mmd_pkg::REGION_DFLASH;
      sel_rom    <= cpu_valid && dec_region == mmd_pkg::REGION_ROM;
      sel_vector <= cpu_valid && dec_vector;
      sel_none   <= cpu_valid && dec_region == mmd_pkg::REGION_NONE;
    end
  end

  // Region of the last valid CPU access, visible to software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_region <= mmd_pkg::REGION_NONE;
    end else if (cpu_valid) begin
      last_region <= dec_region;
    end
  end

  // ============================================================
  // Read data selection.
  logic [7:0] irq_rd;  // Interrupt control register at the access index.

  // OR of every interrupt register whose index matches.
  always_comb begin
    irq_rd = 8'h00;
    for (int i = 0; i < NIRQ; i++) begin
      if (widx == IRQ_IDX[i]) begin
        irq_rd = irq_rd | irq_q[i];
      end
    end
  end

  // Reserved indices read as zero.
  wire logic [7:0] rd_byte =
    (widx == `MMD_IDX_VDC1)   ? voltage_detect_ctrl_1 :
    (widx == `MMD_IDX_VDC2)   ? voltage_detect_ctrl_2 :
    (widx == `MMD_IDX_VM0)    ? voltage_monitor_zero_ctrl :
    (widx == `MMD_IDX_VM1)    ? voltage_monitor_one_ctrl :
    (widx == `MMD_IDX_VM2)    ? voltage_monitor_two_ctrl :
    (widx == `MMD_IDX_PMODE)  ? pin_mode_register :
    (widx == `MMD_IDX_CLKSEL) ? clk_sel :
    (widx == `MMD_IDX_REGION) ? {5'h00, last_region} : irq_rd;

  // ============================================================
  // APB answer: one wait state, then pready for a single cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= (!pwrite && mapped) ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
  end

endmodule

// ==== bench/mmd_top_props.sv ====
`timescale 1ns/1ps
// ============================================================
// Checker on the decoder and reset-value outputs.
module mmd_top_props (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [19:0]  cpu_addr,
  input wire logic         cpu_valid,
  input wire logic         rst_hw,
  input wire logic         rst_por,
  input wire logic         rst_sw,
  input wire logic         rst_mon0,
  input wire logic         monitor_zero_reset_option,
  input wire logic         sel_sfr,
  input wire logic         sel_ram,
  input wire logic         sel_dflash,
  input wire logic         sel_rom,
  input wire logic         sel_vector,
  input wire logic         sel_none,
  input wire logic [7:0]   voltage_detect_ctrl_2,
  input wire logic [7:0]   voltage_monitor_one_ctrl,
  input wire logic [7:0]   voltage_monitor_zero_ctrl,
  input wire logic [111:0] irq_ctrl_flat
);
  // All checks sample on the bus clock and pause in reset.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_onehot;
    cpu_valid |=> $onehot({sel_sfr, sel_ram, sel_dflash, sel_rom, sel_none});
  endproperty
  a_onehot: assert property (p_onehot) else $error("region select not one-hot");
  property p_sfr;
    cpu_valid && cpu_addr inside {[20'h00000:20'h002FF]} |=> sel_sfr;
  endproperty
  a_sfr: assert property (p_sfr) else $error("register area not selected");
  property p_ram;
    cpu_valid && cpu_addr inside {[20'h00400:20'h007FF]} |=> sel_ram;
  endproperty
  a_ram: assert property (p_ram) else $error("ram not selected");
  property p_dfl;
    cpu_valid && cpu_addr inside {[20'h02400:20'h02BFF]} |=> sel_dflash;
  endproperty
  a_dfl: assert property (p_dfl) else $error("data flash not selected");
  property p_rom;
    cpu_valid && cpu_addr inside {[20'h0C000:20'h0FFFF]} |=> sel_rom;
  endproperty
  a_rom: assert property (p_rom) else $error("rom not selected");
  property p_vec;
    cpu_valid && cpu_addr inside {[20'h0FFDC:20'h0FFFF]} |=> sel_vector && sel_rom;
  endproperty
  a_vec: assert property (p_vec) else $error("vector table not flagged");
  property p_err;
    pslverr |-> pready ##1 !pslverr;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_vm1;
    rst_sw && !(rst_hw || rst_por || rst_mon0) |=>
      voltage_monitor_one_ctrl == ($past(voltage_monitor_one_ctrl) & 8'h0C);
  endproperty
  a_vm1: assert property (p_vm1) else $error("monitor one kept bits lost");
  property p_hwopt;
    rst_hw && !rst_por && !rst_mon0 && monitor_zero_reset_option |=>
      voltage_monitor_zero_ctrl == 8'h00 && voltage_detect_ctrl_2 == 8'h00;
  endproperty
  a_hwopt: assert property (p_hwopt) else $error("option reset value wrong");
  property p_irq;
    rst_hw || rst_por || rst_sw |=> irq_ctrl_flat[2:0] == 3'h0 && irq_ctrl_flat[93:92] == 2'h0 &&
      irq_ctrl_flat[90:88] == 3'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt control not cleared");
endmodule

bind mmd_top mmd_top_props u_props (.*);

// ==== bench/mmd_cpu_model.sv ====
`timescale 1ns/1ps
// ============================================================
// CPU core address model on the decoder's CPU side.
module mmd_cpu_model (
  input  wire logic        pclk,
  input  wire logic [19:0] req_addr,
  input  wire logic        req_valid,
  output logic      [19:0] cpu_addr,
  output logic             cpu_valid
);
  // Bus starts idle and defined.
  initial begin
    cpu_addr = 20'h00000;
    cpu_valid = 1'b0;
  end
  // An idle bus inverts the address every cycle, so the last valid address comes back on alternate idle cycles.
  always @(posedge pclk) begin
    cpu_valid <= req_valid;
    cpu_addr <= req_valid ? req_addr : ~cpu_addr;
  end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the memory map decoder.
module tb;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr, err, req_valid, cpu_valid;
  logic                  rst_hw, rst_por, rst_sw, rst_wdt, rst_mon0, rst_mon1, rst_mon2;
  logic                  monitor_zero_reset_option, sel_sfr, sel_ram, sel_dflash, sel_rom, sel_vector, sel_none;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [19:0]           cpu_addr, req_addr;
  logic [7:0]            voltage_detect_ctrl_1, voltage_detect_ctrl_2, voltage_monitor_one_ctrl;
  logic [7:0]            voltage_monitor_two_ctrl, voltage_monitor_zero_ctrl, serial_irq_ctrl, twowire_irq_ctrl;
  logic [111:0]          irq_ctrl_flat;
  mmd_pkg::mmd_clk_src_t sys_clk_source;
  int                    n_mismatch, n_tests, cyc;
  // Decode table: address beside {sfr, ram, dflash, rom, vector, none}.
  logic [19:0]           addr_tab [18] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF, 20'h00400, 20'h007FF,
    20'h00800, 20'h023FF, 20'h02400, 20'h02BFF, 20'h02C00, 20'h0BFFF, 20'h0C000, 20'h0FFDB, 20'h0FFDC,
    20'h10000, 20'hFFFFF, 20'h0FFFF};
  logic [5:0]            sel_tab [18] = '{6'h20, 6'h20, 6'h01, 6'h01, 6'h10, 6'h10, 6'h01, 6'h01, 6'h08,
    6'h08, 6'h01, 6'h01, 6'h04, 6'h04, 6'h06, 6'h01, 6'h01, 6'h06};
  logic [1:0]            clk_tab [4] = '{2'h0, 2'h1, 2'h0, 2'h2};
  // Byte addresses of detect one, monitor one/two and two interrupt controls.
  logic [11:0]           wr_tab [5] = '{12'h0C4, 12'h0D8, 12'h0DC, 12'h11C, 12'h164};
  // Single soft reset pulses: watchdog, monitor one, monitor two.
  logic [6:0]            soft_tab [3] = '{7'h08, 7'h02, 7'h01};

  mmd_cpu_model u_cpu (.*);
  mmd_top dut (.*);

  // Clock of 10 ns period.
  always #5 pclk = ~pclk;

  // Hang guard.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Count a comparison and report a difference.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer, held until ready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // One-cycle pulse on {hw, por, sw, wdt, mon0, mon1, mon2}; check after it lands.
  task automatic rp(input logic [6:0] m);
    @(posedge pclk);
    {rst_hw, rst_por, rst_sw, rst_wdt, rst_mon0, rst_mon1, rst_mon2} <= m;
    @(posedge pclk);
    {rst_hw, rst_por, rst_sw, rst_wdt, rst_mon0, rst_mon1, rst_mon2} <= 7'h00;
    #1;
  endtask

  // Print counts and verdict.
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {psel, penable, pwrite, rst_hw, rst_por, rst_sw, rst_wdt, rst_mon0, rst_mon1, rst_mon2} = '0;
    {monitor_zero_reset_option, req_valid, paddr, pwdata, req_addr} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("vdc2", voltage_detect_ctrl_2, 8'h20);
    chk("vm0", voltage_monitor_zero_ctrl, 8'h41);
    chk("irq", {31'h0, |irq_ctrl_flat}, 0);
    for (int i = 0; i < 18; i++) begin
      @(posedge pclk);
      {req_addr, req_valid} <= {addr_tab[i], 1'b1};
      repeat (2) @(posedge pclk);
      #1;
      chk("sel", {sel_sfr, sel_ram, sel_dflash, sel_rom, sel_vector, sel_none}, sel_tab[i]);
    end
    @(posedge pclk) req_valid <= 1'b0;
    apb(0, 12'h1F8, 0);
    chk("region", rd, mmd_pkg::REGION_ROM);
    apb(0, 12'h0C4, 0);
    chk("vdc1", rd, 8'h08);
    // Deliberate access to a reserved register location.
    apb(1, 12'h004, 32'h5A);
    chk("reserved", {31'h0, err}, 1);
    foreach (wr_tab[i]) apb(1, wr_tab[i], 32'hFF);
    rp(7'h10);
    chk("vdc1 kept", voltage_detect_ctrl_1, 8'hFF);
    chk("vm1 kept", voltage_monitor_one_ctrl, 8'h0C);
    chk("vm2 kept", voltage_monitor_two_ctrl, 8'h0C);
    chk("irq low", irq_ctrl_flat[7:0], 8'hF8);
    chk("pin irq", irq_ctrl_flat[95:88], 8'hC8);
    @(posedge pclk) monitor_zero_reset_option <= 1'b1;
    rp(7'h40);
    chk("vm0 hw", voltage_monitor_zero_ctrl, 8'h00);
    chk("vdc2 hw", voltage_detect_ctrl_2, 8'h00);
    chk("vdc1 hw", voltage_detect_ctrl_1, 8'h08);
    rp(7'h20);
    chk("vm0 por", voltage_monitor_zero_ctrl, 8'h41);
    // Watchdog and monitor one/two resets spare detect one and monitor two bits 3:2.
    foreach (soft_tab[k]) begin
      apb(1, 12'h0C4, 32'h5A);
      apb(1, 12'h0DC, 32'hFF);
      rp(soft_tab[k]);
      chk("vdc1 soft", voltage_detect_ctrl_1, 8'h5A);
      chk("vm2 soft", voltage_monitor_two_ctrl, 8'h0C);
    end
    // A monitor zero reset acts as a full reset.
    apb(1, 12'h0E0, 32'h00);
    rp(7'h04);
    chk("vdc1 mon0", voltage_detect_ctrl_1, 8'h08);
    chk("vm2 mon0", voltage_monitor_two_ctrl, 8'h00);
    chk("vm0 mon0", voltage_monitor_zero_ctrl, 8'h41);
    apb(1, 12'h13C, 32'h55);
    for (int s = 0; s < 2; s++) begin
      apb(1, 12'h1F0, {24'h0, s[0], 7'h0});
      repeat (2) @(posedge pclk);
      #1;
      chk("shared", {serial_irq_ctrl, twowire_irq_ctrl}, s ? 16'h0055 : 16'h5500);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h1F4, i);
      repeat (2) @(posedge pclk);
      #1;
      chk("clk", sys_clk_source, clk_tab[i]);
    end
    // Mid-run bus reset returns the clock source to the external input.
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    #1;
    chk("clk reset", sys_clk_source, mmd_pkg::CLK_EXTERNAL);
    chk("vdc2 reset", voltage_detect_ctrl_2, 8'h20);
    close_out();
  end
endmodule
